// ==== core/voice_port_signaling_test.v ====
// test and maintenance logic of one two-wire exchange-office voice port
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "voice_test_map.vh"

// How it works
// - with watch on and port active, count every bit transition; alarm above 255.
// - transition watch resets off; one command write toggles it.
// - test indicator reads n/a for inactive port or WAN, else off/on.
// - outbound bits pass through, or are replaced by a stored 4-bit pattern.
// - inbound bits pass through, or are replaced by a stored 4-bit pattern.
// - bus-connect systems ignore the inbound override; it stays in monitor.
// - lead drive follows normal control, or is forced to loop or open.
// - cross-connect user path carries PCM, 300 Hz, 1 kHz, 3 kHz or quiet.
// - cross-connect network path carries PCM, a tone or quiet by its selector.
// - bus-connect systems support neither tone selector; both read n/a.
// - tone selectors reset to PCM and offer exactly five choices.
// - a field shows outbound bits sent, the override once applied.
// - a field shows inbound bits received, the override once applied.
// - lead control status reports loop, open, rgnd, lpgnd or ring.
// - lead state decodes tip and ring battery/ground/open, ringing, unknowns, n/a.
// - mode status reports standard, defined network, dial-pulse or ringdown.
// - type status reports the types valid for the current mode.
// - port status reports WAN conditions and call conditions.
// - port status reports trunk conditioning during a carrier group alarm.
// - port status reports test while a signaling override is in force.
// - busy conditioning holds an active call two seconds, drops it, busies port.
module voice_port_signaling_test #(
  parameter [31:0] WINDOW_CYCLES = `WINDOW_CYC,
  parameter [31:0] HOLD_CYCLES   = `HOLD_CYC
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        port_active,
  input  wire        wan_active,
  input  wire        bus_connect,
  input  wire [3:0]  outbound_sig_in,
  input  wire [3:0]  inbound_sig_in,
  output reg  [3:0]  outbound_sig_bits,
  output reg  [3:0]  inbound_sig_bits,
  input  wire [2:0]  lead_normal,
  output reg  [2:0]  lead_drive_control,
  input  wire [1:0]  tip_level,
  input  wire [1:0]  ring_level,
  input  wire        ringing_seen,
  input  wire        lead_sense_valid,
  input  wire        pcm_strobe,
  input  wire [7:0]  net_pcm_in,
  input  wire [7:0]  user_pcm_in,
  output reg  [7:0]  user_pcm_out,
  output reg  [7:0]  net_pcm_out,
  input  wire [1:0]  port_mode,
  input  wire [1:0]  port_type,
  input  wire        port_standby,
  input  wire        wan_standby,
  input  wire        wan_test,
  input  wire        wan_out_of_service,
  input  wire        wan_missing,
  input  wire        call_setup,
  input  wire        call_active,
  input  wire        maintenance,
  input  wire        carrier_group_alarm,
  output reg         call_drop,
  output reg         port_busied,
  output reg         watch_alarm
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_HOLD = 3'b010;
  localparam [2:0] S_BUSY = 3'b100;

  reg  [31:0] ctrl_q;
  reg  [2:0]  user_sel_q;
  reg  [2:0]  net_sel_q;
  reg         watch_on_q;
  reg         wr_pend_q;
  reg  [7:0]  wr_addr_q;
  reg  [3:0]  out_prev_q;
  reg  [3:0]  in_prev_q;
  reg  [31:0] win_cnt_q;
  reg  [31:0] hold_cnt_q;
  reg  [2:0]  cga_st_q;
  reg  [15:0] user_ph_q;
  reg  [15:0] net_ph_q;
  wire [7:0]  toggled;
  wire [7:0]  over;
  wire        addr_ok;
  wire        win_end;
  wire        rx_set;
  wire        sig_test;
  wire        wr_watch;
  reg  [3:0]  lead_state;
  reg  [3:0]  type_code;
  reg  [3:0]  port_status;
  reg  [1:0]  test_state;
  reg  [2:0]  user_rd;
  reg  [2:0]  net_rd;
  reg  [15:0] user_step;
  reg  [15:0] net_step;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign wr_watch  = wr_pend_q & (wr_addr_q == `OFS_WATCH);

  // inbound override is meaningless on a shared bus
  assign rx_set   = ctrl_q[`CTRL_RX_SET] & ~bus_connect;
  assign sig_test = ctrl_q[`CTRL_TX_SET] | rx_set;

  // register writes land in the data phase after the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      ctrl_q     <= 32'h00000000;
      user_sel_q <= `TONE_PCM;
      net_sel_q  <= `TONE_PCM;
      watch_on_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= {haddr[7:2], 2'b00};
      if (wr_pend_q && wr_addr_q == `OFS_CTRL) begin
        ctrl_q <= hwdata & `CTRL_WMASK;
      end
      if (wr_pend_q && wr_addr_q == `OFS_TONE) begin
        // out-of-range codes are refused and the old choice kept
        if (hwdata[2:0] <= `TONE_QUIET) begin
          user_sel_q <= hwdata[2:0];
        end
        if (hwdata[`TONE_NET_POS+2:`TONE_NET_POS] <= `TONE_QUIET) begin
          net_sel_q <= hwdata[`TONE_NET_POS+2:`TONE_NET_POS];
        end
      end
      if (wr_watch && hwdata[0]) begin
        watch_on_q <= ~watch_on_q;
      end
    end
  end

  // read data is captured at the address phase, stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        `OFS_CTRL:  hrdata <= ctrl_q;
        `OFS_TONE:  hrdata <= {25'h0000000, net_rd, 1'b0, user_rd};
        `OFS_WATCH: hrdata <= {30'h00000000, watch_alarm, watch_on_q};
        `OFS_STAT:  hrdata <= {2'b00, test_state, port_status, 2'b00,
                               port_mode, type_code, lead_state, 1'b0,
                               lead_drive_control, inbound_sig_bits,
                               outbound_sig_bits};
        default:    hrdata <= 32'h00000000;
      endcase
    end
  end

  // signaling paths and lead drive
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outbound_sig_bits  <= 4'h0;
      inbound_sig_bits   <= 4'h0;
      lead_drive_control <= `LC_LOOP;
      out_prev_q         <= 4'h0;
      in_prev_q          <= 4'h0;
    end else begin
      outbound_sig_bits <= ctrl_q[`CTRL_TX_SET] ?
        ctrl_q[`CTRL_TX_PAT+3:`CTRL_TX_PAT] : outbound_sig_in;
      inbound_sig_bits <= rx_set ?
        ctrl_q[`CTRL_RX_PAT+3:`CTRL_RX_PAT] : inbound_sig_in;
      if (ctrl_q[`CTRL_LEAD_SET]) begin
        lead_drive_control <= ctrl_q[`CTRL_LEAD_OPN] ?
                              `LC_OPEN : `LC_LOOP;
      end else begin
        lead_drive_control <= lead_normal;
      end
      out_prev_q <= outbound_sig_bits;
      in_prev_q  <= inbound_sig_bits;
    end
  end

  // transition watch: interval timer and one counter per bit
  assign win_end = (win_cnt_q == WINDOW_CYCLES - 32'd1);
  assign toggled = {inbound_sig_bits ^ in_prev_q,
                    outbound_sig_bits ^ out_prev_q};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_cnt_q <= 32'h00000000;
    end else if (win_end || !watch_on_q) begin
      win_cnt_q <= 32'h00000000;
    end else begin
      win_cnt_q <= win_cnt_q + 32'd1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      reg [8:0] c_q;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          c_q <= 9'h000;
        end else if (win_end || !watch_on_q || !port_active) begin
          c_q <= 9'h000;
        end else if (toggled[gi] && c_q != `WATCH_LIMIT) begin
          c_q <= c_q + 9'h001;
        end
      end
      assign over[gi] = (c_q == `WATCH_LIMIT);
    end
  endgenerate

  // alarm latches; a new excess beats a same-cycle clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watch_alarm <= 1'b0;
    end else if (|over) begin
      watch_alarm <= 1'b1;
    end else if (wr_watch && hwdata[1]) begin
      watch_alarm <= 1'b0;
    end
  end

  // carrier group alarm conditioning
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cga_st_q    <= S_IDLE;
      hold_cnt_q  <= 32'h00000000;
      call_drop   <= 1'b0;
      port_busied <= 1'b0;
    end else begin
      case (cga_st_q)
        S_IDLE: begin
          hold_cnt_q <= 32'h00000000;
          if (carrier_group_alarm && ctrl_q[`CTRL_TC_BUSY]) begin
            cga_st_q <= call_active ? S_HOLD : S_BUSY;
            port_busied <= ~call_active;
          end
        end
        S_HOLD: begin
          hold_cnt_q <= hold_cnt_q + 32'd1;
          if (!carrier_group_alarm) begin
            cga_st_q <= S_IDLE;
          end else if (hold_cnt_q == HOLD_CYCLES - 32'd1) begin
            cga_st_q    <= S_BUSY;
            call_drop   <= 1'b1;
            port_busied <= 1'b1;
          end
        end
        S_BUSY: begin
          if (!carrier_group_alarm) begin
            cga_st_q    <= S_IDLE;
            call_drop   <= 1'b0;
            port_busied <= 1'b0;
          end
        end
        default: begin
          cga_st_q    <= S_IDLE;
          call_drop   <= 1'b0;
          port_busied <= 1'b0;
        end
      endcase
    end
  end

  // tone selectors; bus-connect forces pass-through and n/a
  always @* begin
    user_rd = bus_connect ? `TONE_NA : user_sel_q;
    net_rd  = bus_connect ? `TONE_NA : net_sel_q;
    case (user_sel_q)
      `TONE_300: user_step = `STEP_300;
      `TONE_1K:  user_step = `STEP_1K;
      `TONE_3K:  user_step = `STEP_3K;
      default:   user_step = 16'h0000;
    endcase
    case (net_sel_q)
      `TONE_300: net_step = `STEP_300;
      `TONE_1K:  net_step = `STEP_1K;
      `TONE_3K:  net_step = `STEP_3K;
      default:   net_step = 16'h0000;
    endcase
  end

  // square-wave tones advance once per PCM sample
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_ph_q    <= 16'h0000;
      net_ph_q     <= 16'h0000;
      user_pcm_out <= `PCM_QUIET;
      net_pcm_out  <= `PCM_QUIET;
    end else if (pcm_strobe) begin
      user_ph_q <= user_ph_q + user_step;
      net_ph_q  <= net_ph_q + net_step;
      if (bus_connect || user_sel_q == `TONE_PCM) begin
        user_pcm_out <= net_pcm_in;
      end else if (user_sel_q == `TONE_QUIET) begin
        user_pcm_out <= `PCM_QUIET;
      end else begin
        user_pcm_out <= user_ph_q[15] ? `PCM_HI : `PCM_LO;
      end
      if (bus_connect || net_sel_q == `TONE_PCM) begin
        net_pcm_out <= user_pcm_in;
      end else if (net_sel_q == `TONE_QUIET) begin
        net_pcm_out <= `PCM_QUIET;
      end else begin
        net_pcm_out <= net_ph_q[15] ? `PCM_HI : `PCM_LO;
      end
    end
  end

  // lead state decode of the attached device
  always @* begin
    lead_state = `LS_NA;
    if (!lead_sense_valid) begin
      lead_state = `LS_NA;
    end else if (ringing_seen) begin
      lead_state = `LS_RING;
    end else begin
      case ({tip_level, ring_level})
        {`LV_BAT, `LV_GND}:  lead_state = `LS_TBRG;
        {`LV_OPEN, `LV_OPEN}: lead_state = `LS_TORO;
        {`LV_GND, `LV_OPEN}: lead_state = `LS_TGRO;
        {`LV_GND, `LV_BAT}:  lead_state = `LS_RBTG;
        {`LV_OPEN, `LV_BAT}: lead_state = `LS_RBTO;
        {`LV_GND, `LV_UNK}:  lead_state = `LS_TGRX;
        {`LV_OPEN, `LV_UNK}: lead_state = `LS_TORX;
        {`LV_UNK, `LV_OPEN}: lead_state = `LS_ROTX;
        default:             lead_state = `LS_NA;
      endcase
    end
  end

  // type code per mode
  always @* begin
    case (port_mode)
      `MD_STD, `MD_DN: begin
        case (port_type)
          2'h0:    type_code = `TY_LOOP;
          2'h1:    type_code = `TY_GS;
          2'h2:    type_code = `TY_LPFD;
          default: type_code = `TY_R2;
        endcase
      end
      `MD_DPT: begin
        case (port_type)
          2'h1:    type_code = `TY_R2;
          2'h2:    type_code = `TY_IR2;
          default: type_code = `TY_DPT;
        endcase
      end
      default: type_code = `TY_RD;
    endcase
  end

  // port status, WAN conditions ahead of call conditions
  always @* begin
    if (port_standby) begin
      port_status = `ST_PSTB;
    end else if (wan_missing) begin
      port_status = `ST_WAN_MISSING;
    end else if (wan_out_of_service) begin
      port_status = `ST_WOOS;
    end else if (wan_test) begin
      port_status = `ST_WTST;
    end else if (wan_standby) begin
      port_status = `ST_WSTB;
    end else if (carrier_group_alarm) begin
      port_status = `ST_TC;
    end else if (sig_test) begin
      port_status = `ST_TEST;
    end else if (maintenance) begin
      port_status = `ST_MAINT;
    end else if (call_active) begin
      port_status = `ST_BUSY;
    end else if (call_setup) begin
      port_status = `ST_CALL;
    end else begin
      port_status = `ST_IDLE;
    end
    if (!port_active || !wan_active) begin
      test_state = `TS_NA;
    end else begin
      test_state = sig_test ? `TS_ON : `TS_OFF;
    end
  end

endmodule

// ==== core/voice_test_map.vh ====
// register map, field positions and timing counts of the voice port test logic
`ifndef VOICE_TEST_MAP_VH
`define VOICE_TEST_MAP_VH
`define OFS_CTRL      8'h00
`define OFS_TONE      8'h04
`define OFS_WATCH     8'h08
`define OFS_STAT      8'h0C
`define CTRL_TX_SET   0
`define CTRL_RX_SET   1
`define CTRL_LEAD_SET 2
`define CTRL_LEAD_OPN 3
`define CTRL_TC_BUSY  4
`define CTRL_TX_PAT   8
`define CTRL_RX_PAT   12
`define CTRL_WMASK    32'h0000FF1F
`define TONE_NET_POS  4
`define TONE_PCM      3'h0
`define TONE_300      3'h1
`define TONE_1K       3'h2
`define TONE_3K       3'h3
`define TONE_QUIET    3'h4
`define TONE_NA       3'h7
`define STEP_300      16'h099A
`define STEP_1K       16'h2000
`define STEP_3K       16'h6000
`define PCM_HI        8'h9F
`define PCM_LO        8'h1F
`define PCM_QUIET     8'hFF
`define LC_LOOP       3'h0
`define LC_OPEN       3'h1
`define LC_RGND       3'h2
`define LC_LPGND      3'h3
`define LC_RING       3'h4
`define LV_OPEN       2'h0
`define LV_GND        2'h1
`define LV_BAT        2'h2
`define LV_UNK        2'h3
`define LS_NA         4'h0
`define LS_RING       4'h1
`define LS_TBRG       4'h2
`define LS_TORO       4'h3
`define LS_TGRO       4'h4
`define LS_RBTG       4'h5
`define LS_RBTO       4'h6
`define LS_TGRX       4'h7
`define LS_TORX       4'h8
`define LS_ROTX       4'h9
`define TY_LOOP       4'h0
`define TY_GS         4'h1
`define TY_LPFD       4'h2
`define TY_R2         4'h3
`define TY_DPT        4'h4
`define TY_IR2        4'h5
`define TY_RD         4'h6
`define MD_STD        2'h0
`define MD_DN         2'h1
`define MD_DPT        2'h2
`define MD_RD         2'h3
`define ST_PSTB       4'h0
`define ST_WSTB       4'h1
`define ST_WTST       4'h2
`define ST_WOOS       4'h3
`define ST_WAN_MISSING      4'h4
`define ST_CALL       4'h5
`define ST_BUSY       4'h6
`define ST_IDLE       4'h7
`define ST_TC         4'h8
`define ST_TEST       4'h9
`define ST_MAINT      4'hA
`define TS_OFF        2'h0
`define TS_ON         2'h1
`define TS_NA         2'h2
`define WATCH_LIMIT   9'h100
`define CLK_HZ        25000000
`define WINDOW_S      4
`define HOLD_S        2
`define WINDOW_CYC    (`WINDOW_S * `CLK_HZ)
`define HOLD_CYC      (`HOLD_S * `CLK_HZ)
`endif

// ==== tb/far_side_model.sv ====
// far side model: network and station pcm sources at the sample rate
`timescale 1ns/1ps
module far_side_model #(
  parameter integer GAP = 10
) (
  input  wire       hclk,
  input  wire       hresetn,
  output reg        pcm_strobe,
  output reg  [7:0] net_pcm_in,
  output reg  [7:0] user_pcm_in
);
  integer cnt;
  // samples move right after each strobe so a stale copy never matches
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt         <= 0;
      pcm_strobe  <= 1'b0;
      net_pcm_in  <= 8'h00;
      user_pcm_in <= 8'h80;
    end else begin
      cnt        <= (cnt == GAP - 1) ? 0 : cnt + 1;
      pcm_strobe <= (cnt == GAP - 1);
      if (pcm_strobe) begin
        net_pcm_in  <= net_pcm_in + 8'h35;
        user_pcm_in <= user_pcm_in - 8'h17;
      end
    end
  end
endmodule

// ==== tb/sig_test_checker.sv ====
// port assertions of the voice port test logic
`timescale 1ns/1ps
`include "voice_test_map.vh"
module sig_test_checker #(
  parameter [31:0] WINDOW_CYCLES = 32'h40,
  parameter [31:0] HOLD_CYCLES   = 32'h10
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        bus_connect,
  input wire [3:0]  inbound_sig_in,
  input wire [3:0]  inbound_sig_bits,
  input wire        pcm_strobe,
  input wire [7:0]  net_pcm_in,
  input wire [7:0]  user_pcm_in,
  input wire [7:0]  user_pcm_out,
  input wire [7:0]  net_pcm_out,
  input wire        call_active,
  input wire        carrier_group_alarm,
  input wire        call_drop,
  input wire        port_busied,
  input wire        watch_alarm
);
  reg        wr_watch_q;
  reg [31:0] cga_cnt_q;
  // data phase of a watch write, and how long the alarm has stood
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_watch_q <= 1'b0;
      cga_cnt_q  <= 32'h0;
    end else begin
      wr_watch_q <= hsel & hready & htrans[1] & hwrite &
                    (haddr[7:0] == `OFS_WATCH);
      cga_cnt_q  <= carrier_group_alarm ? cga_cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cga_gone;
    $fell(carrier_group_alarm);
  endsequence
  sequence s_drop_start;
    $rose(call_drop);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_busy_release: assert property (s_cga_gone |->
    ##[1:2] (!port_busied && !call_drop))
    else $error("port still busied after alarm cleared");
  a_hold_time: assert property (s_drop_start |->
    cga_cnt_q + 32'h2 >= HOLD_CYCLES)
    else $error("call dropped before hold time");
  a_drop_cause: assert property (s_drop_start |->
    $past(carrier_group_alarm) && $past(call_active))
    else $error("call dropped without alarm and call");
  a_drop_busies: assert property (call_drop |-> port_busied)
    else $error("dropped call without busied port");
  a_alarm_sticky: assert property (
    watch_alarm && !wr_watch_q |=> watch_alarm)
    else $error("watch alarm fell without a clear");
  a_pcm_bus_pass: assert property (
    bus_connect && $past(bus_connect) && pcm_strobe |=>
    user_pcm_out == $past(net_pcm_in) && net_pcm_out == $past(user_pcm_in))
    else $error("pcm not passed through in bus connect");
  a_pcm_hold: assert property (!pcm_strobe |=>
    $stable(user_pcm_out) && $stable(net_pcm_out))
    else $error("pcm output moved without strobe");
  a_rx_locked: assert property (
    bus_connect && $past(bus_connect) |=>
    inbound_sig_bits == $past(inbound_sig_in))
    else $error("inbound bits overridden in bus connect");
endmodule

bind voice_port_signaling_test sig_test_checker #(
  .WINDOW_CYCLES(WINDOW_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)
) sig_test_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .bus_connect(bus_connect),
  .inbound_sig_in(inbound_sig_in), .inbound_sig_bits(inbound_sig_bits),
  .pcm_strobe(pcm_strobe), .net_pcm_in(net_pcm_in),
  .user_pcm_in(user_pcm_in), .user_pcm_out(user_pcm_out),
  .net_pcm_out(net_pcm_out), .call_active(call_active),
  .carrier_group_alarm(carrier_group_alarm), .call_drop(call_drop),
  .port_busied(port_busied), .watch_alarm(watch_alarm)
);

// ==== tb/tb_voice_port_signaling_test.sv ====
// self-checking bench of the voice port test logic
`timescale 1ns/1ps
`include "voice_test_map.vh"
module tb_voice_port_signaling_test;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [2:0]  env = 3'h0;
  reg  [3:0]  obi = 4'h0;
  reg  [3:0]  ibi = 4'h0;
  reg  [2:0]  lnorm = 3'h0;
  reg  [5:0]  lsense = 6'h0;
  reg  [3:0]  md_ty = 4'h0;
  reg  [8:0]  stv = 9'h0;
  wire        hreadyout;
  wire        hresp;
  wire [31:0] hrdata;
  wire [3:0]  obo;
  wire [3:0]  ibo;
  wire [2:0]  ldrv;
  wire        pstr;
  wire [7:0]  npi;
  wire [7:0]  upi;
  wire [7:0]  upo;
  wire [7:0]  npo;
  wire        drop;
  wire        busied;
  wire        alarm;
  reg  [31:0] r;
  reg  [31:0] rnd = 32'h2D25;
  reg  [31:0] ctrl_m = 32'h0;
  reg  [31:0] tone_m = 32'h0;
  reg  [7:0]  e1;
  reg  [7:0]  e2;
  reg  [5:0]  lsv [0:9] = '{6'h00, 6'h30, 6'h29, 6'h20, 6'h24,
                            6'h26, 6'h22, 6'h27, 6'h23, 6'h2C};
  reg  [3:0]  stab [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                             4'h5, 4'h6, 4'hA};
  integer     bad_count = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     i;
  integer     j;
  integer     k;

  voice_port_signaling_test #(
    .WINDOW_CYCLES(32'h400), .HOLD_CYCLES(32'h10)
  ) voice_port_signaling_test_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port_active(env[0]), .wan_active(env[1]),
    .bus_connect(env[2]), .outbound_sig_in(obi), .inbound_sig_in(ibi),
    .outbound_sig_bits(obo), .inbound_sig_bits(ibo),
    .lead_normal(lnorm), .lead_drive_control(ldrv),
    .tip_level(lsense[3:2]), .ring_level(lsense[1:0]),
    .ringing_seen(lsense[4]), .lead_sense_valid(lsense[5]),
    .pcm_strobe(pstr), .net_pcm_in(npi), .user_pcm_in(upi),
    .user_pcm_out(upo), .net_pcm_out(npo), .port_mode(md_ty[3:2]),
    .port_type(md_ty[1:0]), .port_standby(stv[0]), .wan_standby(stv[1]),
    .wan_test(stv[2]), .wan_out_of_service(stv[3]),
    .wan_missing(stv[4]), .call_setup(stv[5]), .call_active(stv[6]),
    .maintenance(stv[7]), .carrier_group_alarm(stv[8]),
    .call_drop(drop), .port_busied(busied), .watch_alarm(alarm)
  );
  far_side_model far_side_model_inst (
    .hclk(hclk), .hresetn(hresetn), .pcm_strobe(pstr),
    .net_pcm_in(npi), .user_pcm_in(upi)
  );

  always #20 hclk = ~hclk;

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] tx(input [2:0] c, input [7:0] p, input [7:0] g);
    if (c == `TONE_PCM) tx = p;
    else if (c == `TONE_QUIET) tx = `PCM_QUIET;
    else tx = (g === `PCM_LO) ? g : `PCM_HI;
  endfunction
  function [3:0] ty_exp(input [3:0] v);
    case (v[3:2])
      2'h2: ty_exp = v[1:0] == 2'h1 ? 4'h3 : v[1:0] == 2'h2 ? 4'h5 : 4'h4;
      2'h3: ty_exp = 4'h6;
      default: ty_exp = {2'h0, v[1:0]};
    endcase
  endfunction

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      bus(1'b1, a, d);
      if (a == `OFS_CTRL) ctrl_m = d & `CTRL_WMASK;
      if (a == `OFS_TONE)
        for (j = 0; j < 8; j = j + 4)
          if (d[j+:3] <= `TONE_QUIET) tone_m[j+:3] = d[j+:3];
    end
  endtask
  task rc(input [7:0] a, input [31:0] e, input string nm);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, r);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  initial begin
    tick(3);
    hresetn <= 1'b1;
    rc(`OFS_CTRL, 32'h0, "ctrl");
    rc(`OFS_TONE, 32'h0, "tone");
    rc(`OFS_WATCH, 32'h0, "watch");
    rc(8'h10, 32'h0, "unmapped");
    $display("test reset done");
    for (k = 0; k < 3; k = k + 1) begin
      wr(`OFS_CTRL, k == 0 ? 32'h0 : 32'h5A04 - k);
      env <= {k == 2, 2'h3};
      for (i = 0; i < 6; i = i + 1) begin
        rnd = lfsr(rnd);
        obi <= rnd[3:0];
        ibi <= rnd[7:4];
        tick(2);
        chk("out", ctrl_m[0] ? ctrl_m[11:8] : obi, obo);
        chk("in", ctrl_m[1] & !env[2] ? ctrl_m[15:12] : ibi, ibo);
      end
      rc(`OFS_CTRL, ctrl_m, "ctrl");
      bus(1'b0, `OFS_STAT, 32'h0);
      e1 = ctrl_m[0] ? ctrl_m[11:8] : obi;
      e2 = ctrl_m[1] & !env[2] ? ctrl_m[15:12] : ibi;
      chk("tx field", e1, r[3:0]);
      chk("rx field", e2, r[7:4]);
      e1 = ctrl_m[0] | (ctrl_m[1] & !env[2]);
      chk("test", e1, r[29:28]);
      chk("status", e1 ? 4'h9 : 4'h7, r[27:24]);
    end
    env <= 3'h2;
    bus(1'b0, `OFS_STAT, 32'h0);
    chk("test na", `TS_NA, r[29:28]);
    chk("status", `ST_TEST, r[27:24]);
    wr(`OFS_CTRL, 32'h0);
    $display("test signaling done");
    for (k = 0; k < 2; k = k + 1) begin
      env <= {k[0], 2'h3};
      for (i = 0; i < 6; i = i + 1) begin
        wr(`OFS_TONE, i < 5 ? i + (4 - i) * 16 : 32'h55);
        rc(`OFS_TONE, k ? 32'h77 : tone_m, "tone");
        @(posedge hclk);
        while (pstr !== 1'b1) @(posedge hclk);
        e1 = npi;
        e2 = upi;
        @(posedge hclk);
        chk("user pcm", tx(k ? 3'h0 : tone_m[2:0], e1, upo), upo);
        chk("net pcm", tx(k ? 3'h0 : tone_m[6:4], e2, npo), npo);
      end
    end
    wr(`OFS_TONE, 32'h0);
    env <= 3'h3;
    $display("test tones done");
    for (i = 0; i < 5; i = i + 1) begin
      lnorm <= i[2:0];
      tick(2);
      chk("lead", i, ldrv);
    end
    wr(`OFS_CTRL, 32'hC);
    tick(2);
    chk("lead open", `LC_OPEN, ldrv);
    wr(`OFS_CTRL, 32'h4);
    tick(2);
    chk("lead loop", `LC_LOOP, ldrv);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk("lead stat", `LC_LOOP, r[10:8]);
    for (i = 0; i < 10; i = i + 1) begin
      lsense <= lsv[i];
      bus(1'b0, `OFS_STAT, 32'h0);
      chk("lead stat", `LC_LOOP, r[10:8]);
      chk("lead state", i, r[15:12]);
    end
    for (i = 0; i < 16; i = i + 1) begin
      md_ty <= i[3:0];
      bus(1'b0, `OFS_STAT, 32'h0);
      chk("lead state", `LS_ROTX, r[15:12]);
      chk("type", ty_exp(i[3:0]), r[19:16]);
      chk("mode", i / 4, r[21:20]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      stv <= 9'h1 << i;
      bus(1'b0, `OFS_STAT, 32'h0);
      chk("test", `TS_OFF, r[29:28]);
      chk("status", stab[i], r[27:24]);
    end
    $display("test status done");
    stv <= 9'h040;
    wr(`OFS_CTRL, 32'h10);
    stv <= 9'h140;
    tick(8);
    chk("held", 1'b0, drop);
    tick(16);
    chk("drop", 1'b1, drop);
    chk("busied", 1'b1, busied);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk("status tc", `ST_TC, r[27:24]);
    chk("test", `TS_OFF, r[29:28]);
    stv <= 9'h040;
    tick(3);
    chk("released", 1'b0, busied);
    stv <= 9'h100;
    tick(3);
    chk("idle busy", 1'b1, busied);
    stv <= 9'h0;
    $display("test conditioning done");
    wr(`OFS_WATCH, 32'h1);
    rc(`OFS_WATCH, 32'h1, "watch on");
    for (k = 0; k < 4; k = k + 1) begin
      if (k == 3) tick(1024);
      repeat (k == 1 ? 100 : 200) begin
        @(posedge hclk);
        obi <= obi ^ 4'h1;
      end
      tick(3);
      chk("alarm", k == 1, alarm);
      if (k == 1) begin
        tick(20);
        rc(`OFS_WATCH, 32'h3, "watch alarm");
        // off empties the saturated counters, so a set cannot beat the clear
        wr(`OFS_WATCH, 32'h1);
        wr(`OFS_WATCH, 32'h3);
        rc(`OFS_WATCH, 32'h1, "watch clear");
      end
    end
    $display("test watch done");
    end_sim;
  end
endmodule
